// file: ppdp_pkg.sv
// Constants, field layouts and types shared by the process data packer
package ppdp_pkg;
  localparam int             NUM_PORTS      = 8;
  localparam int             PORT_W         = 3;
  localparam int             PORT_BYTES     = 32;
  localparam int             MEM_W          = 8;
  localparam logic [5:0]     IN_LEN_MAX     = 6'h21;
  localparam logic [5:0]     OUT_LEN_MAX    = 6'h20;
  localparam logic [5:0]     LEN_ONE        = 6'h01;
  localparam logic [3:0]     FIRST_SUBSLOT  = 4'h2;
  // Register byte addresses
  localparam logic [11:0]    ADDR_CTRL      = 12'h000;
  localparam logic [11:0]    ADDR_IRQ_STAT  = 12'h004;
  localparam logic [11:0]    ADDR_IRQ_MASK  = 12'h008;
  localparam logic [11:0]    ADDR_SC_STATUS = 12'h00C;
  localparam logic [11:0]    ADDR_PORT_CFG  = 12'h020;
  localparam logic [11:0]    ADDR_IN_DATA   = 12'h100;
  localparam logic [11:0]    ADDR_OUT_DATA  = 12'h200;
  // Field positions
  localparam int             CTRL_SRC_BIT   = 0;
  localparam int             CFG_MODE_LSB   = 0;
  localparam int             CFG_IN_LEN_LSB = 8;
  localparam int             CFG_OUT_LEN_LSB = 16;
  localparam int             CFG_ACTIVE_BIT = 24;
  localparam int             Q_ACTIVE_BIT   = 4;
  localparam int             Q_LINK_BIT     = 5;
  localparam int             Q_FAULT_BIT    = 6;
  localparam int             Q_VALID_BIT    = 7;
  localparam int             IRQ_W          = 4;
  localparam int             IRQ_TX_BIT     = 0;
  localparam int             IRQ_RX_BIT     = 1;
  localparam int             IRQ_OVR_BIT    = 2;
  localparam int             IRQ_DI_BIT     = 3;
  // Reset values
  localparam logic [5:0]     CFG_IN_LEN_RST  = 6'h01;
  localparam logic [5:0]     CFG_OUT_LEN_RST = 6'h01;
  localparam logic           CFG_ACTIVE_RST  = 1'b1;
  localparam logic           CTRL_SRC_RST    = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST  = 4'h0;

  typedef enum logic [1:0] {
    PPDP_MODE_COM = 2'h0,
    PPDP_MODE_DI  = 2'h1,
    PPDP_MODE_DO  = 2'h2,
    PPDP_MODE_OFF = 2'h3
  } ppdp_mode_e;

  typedef enum logic {
    PPDP_TX_IDLE = 1'b0,
    PPDP_TX_SEND = 1'b1
  } ppdp_tx_state_e;
endpackage : ppdp_pkg

// file: ppdp_qualifier.sv
// Per-port qualifier byte generator, refreshed every enabled cycle
module ppdp_qualifier
  import ppdp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  // Port state
  input  wire logic       port_operating_flag,
  input  wire logic       device_link_up_flag,
  input  wire logic       port_fault_flag,
  input  wire logic       process_data_valid_flag,
  // Generated byte
  output logic [7:0]      port_qualifier_byte
);
  logic [7:0] qual_ff;

  // Reserved and unsupported bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qual_ff <= 8'h00;
    end else if (clk_en) begin // see [R18]
      qual_ff                <= 8'h00; // see [R17] see [R9]
      qual_ff[Q_ACTIVE_BIT]  <= port_operating_flag; // see [R10]
      qual_ff[Q_LINK_BIT]    <= device_link_up_flag; // see [R11]
      qual_ff[Q_FAULT_BIT]   <= port_fault_flag; // see [R12]
      qual_ff[Q_VALID_BIT]   <= process_data_valid_flag; // see [R13]
    end
  end

  assign port_qualifier_byte = qual_ff;

  a_qual_reserved: assert property (@(posedge pclk) disable iff (!presetn) // see [R17]
    qual_ff[3:0] == 4'h0) else $error("reserved qualifier bits set");
  a_qual_refresh: assert property (@(posedge pclk) disable iff (!presetn) // see [R18]
    clk_en |=> qual_ff[7:4] == {$past(process_data_valid_flag), $past(port_fault_flag),
                                $past(device_link_up_flag), $past(port_operating_flag)})
    else $error("qualifier not refreshed");
endmodule : ppdp_qualifier

// file: ppdp_out_select.sv
// Channel A output driver choosing one data source
module ppdp_out_select
  import ppdp_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  // Sources
  input  wire logic       mode_is_do,
  input  wire logic       output_source_select,
  input  wire logic       port_out_bit,
  input  wire logic       control_bit,
  // Output
  output logic            chan_a_out
);
  logic out_ff;

  // A mux, never an OR: both sources high must not matter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ff <= 1'b0;
    end else if (clk_en) begin
      if (!mode_is_do) begin
        out_ff <= 1'b0;
      end else if (output_source_select) begin
        out_ff <= control_bit; // see [R15] see [R16]
      end else begin
        out_ff <= port_out_bit; // see [R14] see [R16]
      end
    end
  end

  assign chan_a_out = out_ff;

  a_src_control: assert property (@(posedge pclk) disable iff (!presetn) // see [R15]
    clk_en && mode_is_do && output_source_select |=> out_ff == $past(control_bit))
    else $error("output not from control word");
  a_src_port_byte: assert property (@(posedge pclk) disable iff (!presetn) // see [R14]
    clk_en && mode_is_do && !output_source_select |=> out_ff == $past(port_out_bit))
    else $error("output not from port byte");
endmodule : ppdp_out_select

// file: ppdp_top.sv
// Operation
// [R1] Ports one to eight map to sub-slots 2..9
// [R2] Input length 1..33, output 1..32 bytes
// [R3] Controller picks next larger offered length
// [R4] Qualifier byte ends every serial-link input image
// [R5] Digital input: one byte, state in bit 0
// [R6] Digital input image carries no qualifier byte
// [R7] Channel A inputs copied into status word
// [R8] Bit mapping mode never alters port images
// [R9] Controller ignores qualifier bits 2 and 3
// [R10] Bit 4 shows port operating
// [R11] Bit 5 shows field device link up
// [R12] Bit 6 shows port or device fault
// [R13] Bit 7 shows process data valid
// [R14] Digital output driven from output bit 0
// [R15] Control word source ignores port output bit
// [R16] Each output driven by exactly one source
// [R17] Qualifier bits 0 and 1 read zero
// [R18] Qualifier refreshed on every exchange cycle
//
// Register access over APB and the register offsets are this design's own decisions.
module ppdp_top
  import ppdp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // Field side state, same clock
  input  wire logic [7:0]        device_link_up_flag,
  input  wire logic [7:0]        port_fault_flag,
  input  wire logic [7:0]        process_data_valid_flag,
  // Channel A pins
  input  wire logic [7:0]        chan_a_pin,
  output logic [7:0]             chan_a_out,
  // Status/control module words
  input  wire logic [15:0]       sc_control_word,
  output logic [15:0]            sc_status_word,
  // Input image stream to controller
  input  wire logic              cyc_req,
  input  wire logic [2:0]        cyc_port,
  input  wire logic              img_ready,
  output logic                   img_valid,
  output logic [7:0]             img_data,
  output logic                   img_last,
  output logic [3:0]             img_subslot,
  // Output image stream from controller
  input  wire logic              rx_valid,
  input  wire logic [2:0]        rx_port,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_last
);
  ppdp_mode_e     mode_ff [NUM_PORTS];
  logic [5:0]     in_len_ff [NUM_PORTS];
  logic [5:0]     out_len_ff [NUM_PORTS];
  logic [7:0]     port_operating_flag;
  logic           output_source_select;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] nxt_irq_stat;
  logic           irq_ff;
  logic [7:0]     in_mem [NUM_PORTS*PORT_BYTES];
  logic [7:0]     out_mem [NUM_PORTS*PORT_BYTES];
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  logic [31:0]    rd_data;
  logic           addr_ok;
  logic           apb_wr;
  logic [7:0]     di_s1_ff;
  logic [7:0]     di_s2_ff;
  logic [7:0]     di_s3_ff;
  logic [7:0]     di_state_ff;
  logic [7:0]     nxt_di_state;
  logic [7:0]     di_mode;
  logic [15:0]    sc_status_ff;
  logic [7:0]     qual_byte [NUM_PORTS];
  logic [7:0]     port_out_bit;
  ppdp_tx_state_e tx_state_ff;
  logic [2:0]     tx_port_ff;
  logic [5:0]     tx_idx_ff;
  logic           img_valid_ff;
  logic [7:0]     img_data_ff;
  logic           img_last_ff;
  logic [3:0]     img_subslot_ff;
  logic [2:0]     tx_sel_port;
  logic [5:0]     tx_sel_idx;
  logic [5:0]     tx_len;
  logic [7:0]     tx_byte;
  logic           tx_load;
  logic           tx_done_ff;
  logic [5:0]     rx_idx_ff;
  logic [5:0]     rx_limit;
  logic           rx_done_ff;
  logic           rx_ovr_ff;
  logic           di_evt_ff;

  function automatic logic [5:0] clamp_len(input logic [5:0] v, input logic [5:0] mx);
    if (v == 6'h00) begin
      return LEN_ONE;
    end
    if (v > mx) begin
      return mx;
    end
    return v;
  endfunction : clamp_len

  // APB read mux; zero wait state, data registered in setup
  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b0;
    if (paddr[11:8] == ADDR_IN_DATA[11:8]) begin
      addr_ok = 1'b1;
      for (int b = 0; b < 4; b++) begin
        rd_data[8*b +: 8] = in_mem[{paddr[7:2], 2'(b)}];
      end
    end else if (paddr[11:8] == ADDR_OUT_DATA[11:8]) begin
      addr_ok = 1'b1;
      for (int b = 0; b < 4; b++) begin
        rd_data[8*b +: 8] = out_mem[{paddr[7:2], 2'(b)}];
      end
    end else if (paddr[11:5] == ADDR_PORT_CFG[11:5]) begin
      addr_ok = 1'b1;
      rd_data[CFG_MODE_LSB +: 2]    = mode_ff[paddr[4:2]];
      rd_data[CFG_IN_LEN_LSB +: 6]  = in_len_ff[paddr[4:2]];
      rd_data[CFG_OUT_LEN_LSB +: 6] = out_len_ff[paddr[4:2]];
      rd_data[CFG_ACTIVE_BIT]       = port_operating_flag[paddr[4:2]];
    end else begin
      case (paddr)
        ADDR_CTRL: begin
          addr_ok = 1'b1;
          rd_data[CTRL_SRC_BIT] = output_source_select;
        end
        ADDR_IRQ_STAT: begin
          addr_ok = 1'b1;
          rd_data[IRQ_W-1:0] = irq_stat_ff;
        end
        ADDR_IRQ_MASK: begin
          addr_ok = 1'b1;
          rd_data[IRQ_W-1:0] = irq_mask_ff;
        end
        ADDR_SC_STATUS: begin
          addr_ok = 1'b1;
          rd_data[15:0] = sc_status_ff;
        end
        default: begin
          addr_ok = 1'b0;
        end
      endcase
    end
  end

  assign apb_wr = psel & penable & pready_ff & pwrite & addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      pready_ff <= psel & ~penable;
      if (psel && !penable) begin
        prdata_ff  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_ff <= ~addr_ok;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Configuration; lengths saturate into the offered range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        mode_ff[p]    <= PPDP_MODE_COM;
        in_len_ff[p]  <= CFG_IN_LEN_RST;
        out_len_ff[p] <= CFG_OUT_LEN_RST;
      end
      port_operating_flag  <= {NUM_PORTS{CFG_ACTIVE_RST}};
      output_source_select <= CTRL_SRC_RST;
      irq_mask_ff          <= IRQ_MASK_RST;
    end else if (clk_en && apb_wr) begin
      if (paddr[11:5] == ADDR_PORT_CFG[11:5]) begin
        mode_ff[paddr[4:2]]    <= ppdp_mode_e'(pwdata[CFG_MODE_LSB +: 2]);
        in_len_ff[paddr[4:2]]  <= clamp_len(pwdata[CFG_IN_LEN_LSB +: 6], IN_LEN_MAX); // see [R2]
        out_len_ff[paddr[4:2]] <= clamp_len(pwdata[CFG_OUT_LEN_LSB +: 6], OUT_LEN_MAX); // see [R2]
        port_operating_flag[paddr[4:2]] <= pwdata[CFG_ACTIVE_BIT];
      end else if (paddr == ADDR_CTRL) begin
        output_source_select <= pwdata[CTRL_SRC_BIT];
      end else if (paddr == ADDR_IRQ_MASK) begin
        irq_mask_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Field device input data written by software, no reset on storage
  always_ff @(posedge pclk) begin
    if (clk_en && apb_wr && paddr[11:8] == ADDR_IN_DATA[11:8]) begin
      for (int b = 0; b < 4; b++) begin
        in_mem[{paddr[7:2], 2'(b)}] <= pwdata[8*b +: 8];
      end
    end
  end

  // Channel A pins: three stages, accepted once stages two and three agree
  assign nxt_di_state = (~(di_s2_ff ^ di_s3_ff) & di_s3_ff) | ((di_s2_ff ^ di_s3_ff) & di_state_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      di_s1_ff    <= 8'h00;
      di_s2_ff    <= 8'h00;
      di_s3_ff    <= 8'h00;
      di_state_ff <= 8'h00;
    end else if (clk_en) begin
      di_s1_ff    <= chan_a_pin;
      di_s2_ff    <= di_s1_ff;
      di_s3_ff    <= di_s2_ff;
      di_state_ff <= nxt_di_state;
    end
  end

  // Status word copy; no mapping-mode input exists, images stay untouched
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      di_mode[p] = (mode_ff[p] == PPDP_MODE_DI);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_status_ff <= 16'h0000;
      di_evt_ff    <= 1'b0;
    end else if (clk_en) begin
      sc_status_ff <= {8'h00, di_state_ff & di_mode}; // see [R7] see [R8]
      di_evt_ff    <= |((nxt_di_state ^ di_state_ff) & di_mode);
    end
  end

  // Per-port qualifier and output drivers
  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    assign port_out_bit[g] = out_mem[{3'(g), 5'h00}][0];

    ppdp_qualifier u_qual (
      .pclk                    (pclk),
      .presetn                 (presetn),
      .clk_en                  (clk_en),
      .port_operating_flag     (port_operating_flag[g]),
      .device_link_up_flag     (device_link_up_flag[g]),
      .port_fault_flag         (port_fault_flag[g]),
      .process_data_valid_flag (process_data_valid_flag[g]),
      .port_qualifier_byte     (qual_byte[g])
    );

    ppdp_out_select u_out (
      .pclk                 (pclk),
      .presetn              (presetn),
      .clk_en               (clk_en),
      .mode_is_do           (mode_ff[g] == PPDP_MODE_DO),
      .output_source_select (output_source_select),
      .port_out_bit         (port_out_bit[g]),
      .control_bit          (sc_control_word[g]),
      .chan_a_out           (chan_a_out[g])
    );
  end

  // Next image byte; idle selects byte 0 of the requested port
  always_comb begin
    tx_sel_port = (tx_state_ff == PPDP_TX_IDLE) ? cyc_port : tx_port_ff;
    tx_sel_idx  = (tx_state_ff == PPDP_TX_IDLE) ? 6'h00 : tx_idx_ff + LEN_ONE;
    tx_len      = in_len_ff[tx_sel_port];
    tx_byte     = 8'h00;
    case (mode_ff[tx_sel_port])
      PPDP_MODE_DI: begin
        tx_len  = LEN_ONE; // see [R6]
        tx_byte = {7'h00, di_state_ff[tx_sel_port]}; // see [R5]
      end
      PPDP_MODE_DO: begin
        tx_len  = LEN_ONE;
        tx_byte = 8'h00;
      end
      default: begin
        if (tx_sel_idx == tx_len - LEN_ONE) begin
          tx_byte = qual_byte[tx_sel_port]; // see [R4]
        end else begin
          tx_byte = in_mem[{tx_sel_port, tx_sel_idx[4:0]}];
        end
      end
    endcase
  end

  assign tx_load = (tx_state_ff == PPDP_TX_IDLE) ? cyc_req : (img_ready && !img_last_ff);

  // Image sender; a request while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff    <= PPDP_TX_IDLE;
      tx_port_ff     <= 3'h0;
      tx_idx_ff      <= 6'h00;
      img_valid_ff   <= 1'b0;
      img_data_ff    <= 8'h00;
      img_last_ff    <= 1'b0;
      img_subslot_ff <= 4'h0;
      tx_done_ff     <= 1'b0;
    end else if (clk_en) begin
      tx_done_ff <= 1'b0;
      case (tx_state_ff)
        PPDP_TX_IDLE: begin
          if (cyc_req) begin
            tx_state_ff    <= PPDP_TX_SEND;
            tx_port_ff     <= cyc_port;
            tx_idx_ff      <= 6'h00;
            img_valid_ff   <= 1'b1;
            img_data_ff    <= tx_byte;
            img_last_ff    <= (tx_len == LEN_ONE);
            img_subslot_ff <= FIRST_SUBSLOT + {1'b0, cyc_port}; // see [R1]
          end
        end
        PPDP_TX_SEND: begin
          if (img_ready && img_last_ff) begin
            tx_state_ff  <= PPDP_TX_IDLE;
            img_valid_ff <= 1'b0;
            img_last_ff  <= 1'b0;
            tx_done_ff   <= 1'b1;
          end else if (tx_load) begin
            tx_idx_ff   <= tx_sel_idx;
            img_data_ff <= tx_byte;
            img_last_ff <= (tx_sel_idx == tx_len - LEN_ONE);
          end
        end
        default: begin
          tx_state_ff  <= PPDP_TX_IDLE;
          img_valid_ff <= 1'b0;
        end
      endcase
    end
  end

  // Output image receiver; bytes past the configured length in com mode, or past byte 0 in other modes, are dropped
  assign rx_limit = (mode_ff[rx_port] == PPDP_MODE_COM) ? out_len_ff[rx_port] : LEN_ONE; // see [R14]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_idx_ff  <= 6'h00;
      rx_done_ff <= 1'b0;
      rx_ovr_ff  <= 1'b0;
    end else if (clk_en) begin
      rx_done_ff <= rx_valid & rx_last;
      rx_ovr_ff  <= rx_valid & (rx_idx_ff >= rx_limit);
      if (rx_valid) begin
        rx_idx_ff <= rx_last ? 6'h00 : ((rx_idx_ff == OUT_LEN_MAX) ? rx_idx_ff : rx_idx_ff + LEN_ONE);
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (clk_en && rx_valid && rx_idx_ff < rx_limit) begin
      out_mem[{rx_port, rx_idx_ff[4:0]}] <= rx_data;
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (apb_wr && paddr == ADDR_IRQ_STAT) begin
      nxt_irq_stat = irq_stat_ff & ~pwdata[IRQ_W-1:0];
    end
    nxt_irq_stat[IRQ_TX_BIT]  = nxt_irq_stat[IRQ_TX_BIT] | tx_done_ff;
    nxt_irq_stat[IRQ_RX_BIT]  = nxt_irq_stat[IRQ_RX_BIT] | rx_done_ff;
    nxt_irq_stat[IRQ_OVR_BIT] = nxt_irq_stat[IRQ_OVR_BIT] | rx_ovr_ff;
    nxt_irq_stat[IRQ_DI_BIT]  = nxt_irq_stat[IRQ_DI_BIT] | di_evt_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= {IRQ_W{1'b0}};
      irq_ff      <= 1'b0;
    end else if (clk_en) begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign irq            = irq_ff;
  assign sc_status_word = sc_status_ff;
  assign img_valid      = img_valid_ff;
  assign img_data       = img_data_ff;
  assign img_last       = img_last_ff;
  assign img_subslot    = img_subslot_ff;

  a_subslot_map: assert property (@(posedge pclk) disable iff (!presetn) // see [R1]
    img_valid_ff |-> img_subslot_ff == FIRST_SUBSLOT + {1'b0, tx_port_ff})
    else $error("wrong sub-slot for port");
  a_len_range: assert property (@(posedge pclk) disable iff (!presetn) // see [R2]
    img_valid_ff |-> tx_idx_ff < IN_LEN_MAX && in_len_ff[tx_port_ff] != 6'h00)
    else $error("input image length out of range");
  a_qual_last: assert property (@(posedge pclk) disable iff (!presetn) // see [R4]
    clk_en && tx_load && mode_ff[tx_sel_port] == PPDP_MODE_COM && tx_sel_idx == tx_len - LEN_ONE
    |=> img_last_ff && img_data_ff == $past(qual_byte[tx_sel_port]))
    else $error("qualifier not in last byte");
  a_di_one_byte: assert property (@(posedge pclk) disable iff (!presetn) // see [R5] see [R6]
    clk_en && tx_state_ff == PPDP_TX_IDLE && cyc_req && mode_ff[cyc_port] == PPDP_MODE_DI
    |=> img_valid_ff && img_last_ff && img_data_ff == {7'h00, $past(di_state_ff[cyc_port])})
    else $error("digital input image wrong");
  a_status_copy: assert property (@(posedge pclk) disable iff (!presetn) // see [R7]
    clk_en |=> sc_status_ff[7:0] == ($past(di_state_ff) & $past(di_mode)) && sc_status_ff[15:8] == 8'h00)
    else $error("status word not copied");
  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && tx_done_ff |=> irq_stat_ff[IRQ_TX_BIT])
    else $error("event lost");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable |=> pready_ff)
    else $error("no answer in access phase");

  c_di_frame: cover property (@(posedge pclk) disable iff (!presetn)
    img_valid_ff && img_last_ff && mode_ff[tx_port_ff] == PPDP_MODE_DI);
  c_com_frame: cover property (@(posedge pclk) disable iff (!presetn)
    tx_done_ff && in_len_ff[tx_port_ff] > LEN_ONE);
  c_rx_overrun: cover property (@(posedge pclk) disable iff (!presetn) rx_ovr_ff);
  c_irq_raised: cover property (@(posedge pclk) disable iff (!presetn) irq_ff);
endmodule : ppdp_top

// file: ppdp_ctrl_model.sv
// Controller model: takes input images, sends output images
module ppdp_ctrl_model (
  // Clock
  input  wire logic       pclk,
  // Input image stream
  input  wire logic       img_valid,
  input  wire logic [7:0] img_data,
  input  wire logic       img_last,
  input  wire logic [3:0] img_subslot,
  output logic            img_ready,
  // Output image stream
  output logic            rx_valid,
  output logic [2:0]      rx_port,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  timeunit 1ns;
  timeprecision 1ns;
  int          seed = 70907;
  logic [12:0] got[$];
  initial begin
    {img_ready, rx_valid, rx_port, rx_data, rx_last} = '0;
  end
  // Random stalls so held bytes are exercised
  always @(posedge pclk) begin
    if (img_valid && img_ready) got.push_back({img_subslot, img_last, img_data});
    img_ready <= 1'($random(seed));
  end
  task automatic send(input logic [2:0] p, input logic [7:0] b);
    @(posedge pclk);
    {rx_port, rx_data, rx_valid, rx_last} <= {p, b, 2'h3};
    @(posedge pclk);
    // Idle data inverted so stale bytes never look valid
    {rx_data, rx_valid, rx_last} <= {~b, 2'h0};
  endtask : send
endmodule : ppdp_ctrl_model

// file: tb_top.sv
// Self-checking bench for the process data packer
module tb_top
  import ppdp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, cyc_req = 0;
  logic        pready, pslverr, irq, img_ready, img_valid, img_last, rx_valid, rx_last, e;
  logic [2:0]  cyc_port = 0, rx_port;
  logic [3:0]  img_subslot;
  logic [7:0]  lnk = 0, flt = 0, vld = 0, pin = 0, chan_a_out, img_data, rx_data;
  logic [11:0] paddr = 0;
  logic [15:0] ctl = 0, sc_status_word;
  logic [31:0] pwdata = 0, prdata, r, w;
  logic [12:0] exq[$];
  int          seed = 70907, fails = 0, compares = 0;
  ppdp_top u_ppdp_top (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .device_link_up_flag(lnk),
    .port_fault_flag(flt), .process_data_valid_flag(vld), .chan_a_pin(pin), .chan_a_out,
    .sc_control_word(ctl), .sc_status_word, .cyc_req, .cyc_port, .img_ready, .img_valid,
    .img_data, .img_last, .img_subslot, .rx_valid, .rx_port, .rx_data, .rx_last);
  ppdp_ctrl_model u_ppdp_ctrl_model (.pclk, .img_valid, .img_data, .img_last,
    .img_subslot, .img_ready, .rx_valid, .rx_port, .rx_data, .rx_last);
  initial begin
    forever #50 pclk = ~pclk;
  end
  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    compares++;
    if (s !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n == 20) fails++;
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask : apb
  task automatic cfg(input int p, input logic [1:0] md, input logic [5:0] il, input logic a);
    apb(1, ADDR_PORT_CFG + 12'(4 * p), {7'h0, a, 2'h0, 6'h01, 2'h0, il, 6'h0, md});
  endtask : cfg
  task automatic req(input logic [2:0] p);
    int          k = 0;
    logic [12:0] m;
    u_ppdp_ctrl_model.got.delete();
    @(posedge pclk);
    {cyc_req, cyc_port} <= {1'b1, p};
    @(posedge pclk);
    cyc_req <= 1'b0;
    while (u_ppdp_ctrl_model.got.size() < exq.size() && k++ < 300) @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk("img_len", exq.size(), u_ppdp_ctrl_model.got.size());
    foreach (exq[i]) begin
      m = exq[i][8] ? 13'h1FF3 : 13'h1FFF;
      chk("img_byte", exq[i] & m, u_ppdp_ctrl_model.got[i] & m);
    end
    exq.delete();
  endtask : req
  initial begin
    int p, len;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_PORT_CFG, 0);
    chk("cfg_rst", 32'h0101_0100, r);
    apb(0, 12'hFFC, 0);
    chk("slverr", 1, e);
    $display("regs done");
    apb(1, ADDR_IRQ_MASK, 1);
    for (int t = 0; t < 2; t++) begin
      p = t ? 2 : 5;
      len = t ? 1 : 33;
      {lnk, flt, vld} <= 24'($random(seed));
      cfg(p, 2'h0, 6'(len), !t);
      for (int i = 0; i < (len - 1) / 4; i++) begin
        w = $random(seed);
        apb(1, ADDR_IN_DATA + 12'(32 * p + 4 * i), w);
        for (int k = 0; k < 4; k++) exq.push_back({4'(p + 2), 1'b0, w[8*k+:8]});
      end
      exq.push_back({4'(p + 2), 1'b1, vld[p], flt[p], lnk[p], !t, 4'h0});
      req(3'(p));
      repeat (2) @(posedge pclk);
      chk("irq_set", 1, irq);
      apb(1, ADDR_IRQ_STAT, 1);
      repeat (2) @(posedge pclk);
      chk("irq_clr", 0, irq);
    end
    $display("com done");
    pin <= 8'($random(seed));
    cfg(3, 2'h1, 1, 1);
    repeat (6) @(posedge pclk);
    exq.push_back({4'h5, 1'b1, 7'h0, pin[3]});
    req(3);
    chk("status", {8'h0, pin & 8'h08}, sc_status_word);
    $display("di done");
    cfg(3, 2'h2, 1, 1);
    ctl <= 16'($random(seed)) & 16'hFFF7;
    u_ppdp_ctrl_model.send(3, 8'h01);
    repeat (3) @(posedge pclk);
    chk("do_byte", 8'h08, chan_a_out);
    apb(1, ADDR_CTRL, 1);
    repeat (3) @(posedge pclk);
    chk("do_ctl0", 0, chan_a_out);
    ctl <= 16'h0008;
    repeat (3) @(posedge pclk);
    chk("do_ctl1", 8'h08, chan_a_out);
    $display("do done");
    stop_test();
  end
  // Whole run is a few hundred cycles
  initial begin
    #1ms;
    fails++;
    stop_test();
  end
endmodule : tb_top
